// *** verilog/scd_pkg.sv ***
// Purpose: Shared constants and types for the sample clock divider and alignment block
// Assumes: One clock (mclk), synchronous active-high reset
// Notes:   Register port is a simple strobe/address/data port, no public bus
package scd_pkg;

  // Register map
  localparam logic [8:0] SYNC_CTRL_OFFSET = 9'h100;

  // Divider-sync control fields
  localparam int         ENABLE_BIT       = 0;
  localparam int         ONESHOT_BIT      = 1;
  localparam int         CORR_EN_BIT      = 2;
  localparam int         RATIO_LSB        = 4;
  localparam int         RATIO_W          = 3;
  localparam logic [7:0] SYNC_CTRL_RESET  = 8'h04;
  localparam logic [7:0] SYNC_CTRL_MASK   = 8'h77;

  // Correction loop timing
  localparam int CLK_MHZ          = 100;
  localparam int MIN_CORR_MHZ     = 20;
  localparam int LOCK_TIME_NS     = 1500;
  localparam int LOCK_CYCLES      = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_PERIOD_CYC   = CLK_MHZ / MIN_CORR_MHZ;
  localparam int CNT_W            = 12;

  // Register port request
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } scd_req_s;

  // Alignment handling modes
  typedef enum logic [1:0]
  {
    SCD_IDLE,
    SCD_ARMED,
    SCD_DONE
  } scd_mode_e;

endpackage : scd_pkg

// *** verilog/scd_lock.sv ***
// Purpose: Lock tracker for the duty-cycle correction loop
// Assumes: Input period change is signalled by freq_change pulse
// Notes:   Locked only after settle time and while rate is above the floor
`timescale 1ns/1ps
module scd_lock
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Control
  input  wire logic enable,
  input  wire logic freq_change,
  input  wire logic rate_ok,
  // Status
  output logic      locked
);

  logic [scd_pkg::CNT_W-1:0] cnt_reg;
  logic                      locked_reg;

  assign locked = locked_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Settle counter restarts on every frequency change or loss of rate
  always_ff @(posedge mclk)
  begin
    if (rst || !enable || freq_change || !rate_ok)
    begin
      cnt_reg    <= '0;
      locked_reg <= 1'b0;
    end
    else if (cnt_reg == scd_pkg::CNT_W'(scd_pkg::LOCK_CYCLES))
      locked_reg <= 1'b1;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

endmodule : scd_lock

// *** verilog/scd_divider.sv ***
// Purpose: Integer 1..8 sample clock divider with alignment input and duty-cycle corrector
// Assumes: Sample clock edges appear as clk_in levels sampled on mclk
// Notes:   Corrected output is high for half the divided period; raw follows input at ratio 1 only
`timescale 1ns/1ps
module scd_divider
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Register port
  input  wire scd_pkg::scd_req_s req,
  output logic [7:0]            rdata,
  // Sample clock and alignment
  input  wire logic             clk_in,
  input  wire logic             align_in,
  input  wire logic             freq_change,
  // Core timing
  output logic                  core_clk,
  output logic                  corr_locked,
  output logic                  align_seen
);

  logic [7:0]               ctrl_reg;
  logic [7:0]               rdata_reg;
  logic                     sync1_reg;
  logic                     sync2_reg;
  logic                     sync3_reg;
  logic                     clk_d_reg;
  logic [2:0]               div_reg;
  logic                     raw_reg;
  logic                     core_reg;
  logic                     seen_reg;
  logic [scd_pkg::CNT_W-1:0] per_reg;
  logic [scd_pkg::CNT_W-1:0] hi_reg;
  logic [scd_pkg::CNT_W-1:0] half_reg;
  logic                     rate_ok_reg;
  scd_pkg::scd_mode_e       mode_reg;
  scd_pkg::scd_mode_e       mode_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  wire       ctrl_hit  = (req.addr == scd_pkg::SYNC_CTRL_OFFSET);
  wire       ctrl_wr   = req.wr && ctrl_hit;
  wire       in_rise   = clk_in && !clk_d_reg;
  wire       in_fall   = !clk_in && clk_d_reg;
  wire [2:0] ratio_m1  = ctrl_reg[scd_pkg::RATIO_LSB +: scd_pkg::RATIO_W];
  wire       sync_rise = sync2_reg && !sync3_reg;
  wire       align_en  = ctrl_reg[scd_pkg::ENABLE_BIT];
  wire       oneshot   = ctrl_reg[scd_pkg::ONESHOT_BIT];
  wire       corr_en   = ctrl_reg[scd_pkg::CORR_EN_BIT];
  wire       lock_ok;
  // Accept every pulse, or only the first one after a write
  wire       accept    = sync_rise && align_en &&
                         (!oneshot || mode_reg == scd_pkg::SCD_ARMED);
  wire       wrap      = in_rise && (div_reg == ratio_m1);

  ////////////////////////////////////////////////////////////////////////////
  // Control register; reserved bits read zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_reg <= scd_pkg::SYNC_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= req.wdata & scd_pkg::SYNC_CTRL_MASK;
  end

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (req.rd)
      rdata_reg <= ctrl_hit ? ctrl_reg : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alignment synchroniser; the second and third stages feed the edge detector
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= align_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // One-shot arming: a write re-arms, an accepted pulse disarms
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      scd_pkg::SCD_IDLE:  mode_next = scd_pkg::SCD_IDLE;
      scd_pkg::SCD_ARMED: if (accept) mode_next = scd_pkg::SCD_DONE;
      scd_pkg::SCD_DONE:  mode_next = scd_pkg::SCD_DONE;
      default:            mode_next = scd_pkg::SCD_IDLE;
    endcase
    if (ctrl_wr)
      mode_next = scd_pkg::SCD_ARMED;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      mode_reg <= scd_pkg::SCD_IDLE;
    else
      mode_reg <= mode_next;
  end

  // Sticky flag that a realignment happened; a control write clears it unless a pulse is accepted in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
      seen_reg <= 1'b0;
    else if (accept)
      seen_reg <= 1'b1;
    else if (ctrl_wr)
      seen_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider counter counts input rising edges
  always_ff @(posedge mclk)
  begin
    if (rst)
      clk_d_reg <= 1'b0;
    else
      clk_d_reg <= clk_in;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || accept)
      div_reg <= 3'h0;
    else if (wrap)
      div_reg <= 3'h0;
    else if (in_rise)
      div_reg <= div_reg + 3'h1;
  end

  // Raw divided clock: rises on wrap; falls at the raw input fall for ratio 1,
  // else on the count midpoint, so odd ratios skew unless corrected
  wire raw_fall = (ratio_m1 == 3'h0) ? in_fall :
                  (in_rise && (div_reg == (ratio_m1 >> 1)));
  always_ff @(posedge mclk)
  begin
    if (rst || accept)
      raw_reg <= 1'b0;
    else if (wrap)
      raw_reg <= 1'b1;
    else if (raw_fall)
      raw_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Corrector: measure the output period and rebuild the falling edge
  always_ff @(posedge mclk)
  begin
    if (rst || accept)
    begin
      per_reg     <= '0;
      half_reg    <= '0;
      rate_ok_reg <= 1'b0;
    end
    else if (wrap)
    begin
      per_reg     <= '0;
      // The count at a wrap is one short of the period, so add its low bit back
      half_reg    <= (per_reg >> 1) + {{(scd_pkg::CNT_W-1){1'b0}}, per_reg[0]};
      // Too slow an input means the loop cannot be trusted
      rate_ok_reg <= (per_reg < scd_pkg::CNT_W'(scd_pkg::MAX_PERIOD_CYC * (ratio_m1 + 1)));
    end
    else if (per_reg != {scd_pkg::CNT_W{1'b1}})
      per_reg <= per_reg + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || wrap)
      hi_reg <= '0;
    else if (hi_reg != {scd_pkg::CNT_W{1'b1}})
      hi_reg <= hi_reg + 1'b1;
  end

  // Lock tracker bounds the relock wait after a rate change
  scd_lock u_lock
  (
    .mclk        (mclk),
    .rst         (rst),
    .enable      (corr_en),
    .freq_change (freq_change),
    .rate_ok     (rate_ok_reg),
    .locked      (lock_ok)
  );

  // Output choice: corrected half-period high when locked, raw otherwise
  wire corr_fall = (hi_reg + 1'b1 >= half_reg);
  always_ff @(posedge mclk)
  begin
    if (rst || accept)
      core_reg <= 1'b0;
    else if (wrap)
      core_reg <= 1'b1;
    else if (corr_en && lock_ok)
      core_reg <= core_reg && !corr_fall;
    else
      core_reg <= raw_reg && !raw_fall;
  end

  assign core_clk    = core_reg;
  assign corr_locked = lock_ok;
  assign align_seen  = seen_reg;
  assign rdata       = rdata_reg;

endmodule : scd_divider

// *** bench/scd_divider_asserts.sv ***
// Purpose: Port checks for the sample clock divider
// Assumes: Control shadow follows writes to the sync control register
// Notes:   Lock time is checked with a small margin
`timescale 1ns/1ps
module scd_chk
(
  // Clock, reset and register port
  input wire logic              mclk,
  input wire logic              rst,
  input wire scd_pkg::scd_req_s req,
  input wire logic [7:0]        rdata,
  // Alignment and core timing
  input wire logic              align_in,
  input wire logic              freq_change,
  input wire logic              core_clk,
  input wire logic              corr_locked,
  input wire logic              align_seen
);
  logic [7:0]  ctrl_reg;
  logic [11:0] quiet_reg;
  wire         ctrl_wr = req.wr && req.addr == scd_pkg::SYNC_CTRL_OFFSET;
  wire         ctrl_rd = req.rd && req.addr == scd_pkg::SYNC_CTRL_OFFSET;
  // Shadow control; quiet time saturates so a long run cannot wrap it
  always_ff @(posedge mclk)
  begin
    ctrl_reg  <= rst ? scd_pkg::SYNC_CTRL_RESET : ctrl_wr ? req.wdata : ctrl_reg;
    quiet_reg <= (rst || freq_change || !ctrl_reg[2]) ? 12'h000 : quiet_reg + {11'h0, ~&quiet_reg};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_unmapped;
    req.rd && req.addr != scd_pkg::SYNC_CTRL_OFFSET |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_readback;
    ctrl_rd && !req.wr |=> rdata == (ctrl_reg & scd_pkg::SYNC_CTRL_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("control readback wrong");
  property p_align;
    $rose(align_in) && ctrl_reg[1:0] == 2'b01 |-> ##[2:4] align_seen;
  endproperty
  a_align: assert property (p_align) else $error("alignment not taken");
  property p_no_align;
    !ctrl_reg[0] && !align_seen |=> !align_seen;
  endproperty
  a_no_align: assert property (p_no_align) else $error("alignment taken while off");
  property p_lock_time;
    $rose(corr_locked) |-> quiet_reg >= 12'(scd_pkg::LOCK_CYCLES - 4);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock came early");
  property p_unlock;
    freq_change |-> ##[1:2] !corr_locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock kept after rate change");
  property p_corr_off;
    !ctrl_reg[2] [*3] |-> !corr_locked;
  endproperty
  a_corr_off: assert property (p_corr_off) else $error("lock while corrector off");
  property p_reset;
    $fell(rst) |-> rdata == 8'h00 && !core_clk && !corr_locked && !align_seen;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule : scd_chk
bind scd_divider scd_chk u_chk (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
  .align_in(align_in), .freq_change(freq_change), .core_clk(core_clk),
  .corr_locked(corr_locked), .align_seen(align_seen));

// *** bench/scd_clk_src.sv ***
// Purpose: Far-side sample clock source and alignment pulse driver
// Assumes: Half period given in system clock cycles
// Notes:   Clock runs free, as a sample clock does
`timescale 1ns/1ps
module scd_clk_src
(
  // Bench control
  input wire logic       mclk,
  input wire logic [3:0] half_cyc,
  input wire logic       align_go,
  // Far-side lines
  output logic           clk_in,
  output logic           align_in
);
  logic [3:0] cnt_reg  = 4'h0;
  logic [1:0] hold_reg = 2'h0;
  logic       pend_reg = 1'b0;
  logic       clk_reg  = 1'b0;
  logic       al_reg   = 1'b0;
  wire        wrap     = cnt_reg == half_cyc - 4'h1;
  wire        launch   = pend_reg & wrap & ~clk_reg;
  // Pulse starts with a clock rise so every part sees it on the same edge
  always @(negedge mclk)
  begin
    cnt_reg  <= wrap ? 4'h0 : cnt_reg + 4'h1;
    clk_reg  <= clk_reg ^ wrap;
    pend_reg <= align_go | (pend_reg & ~launch);
    hold_reg <= launch ? 2'h3 : hold_reg - {1'b0, |hold_reg};
    al_reg   <= launch | (hold_reg > 2'h1);
  end
  assign clk_in   = clk_reg;
  assign align_in = al_reg;
endmodule : scd_clk_src

// *** bench/scd_divider_tb.sv ***
// Purpose: Self-checking bench for the sample clock divider
// Assumes: Source half period of one or two cycles, above the rate floor, and four cycles for the slow case
// Notes:   Fixed seed keeps runs repeatable
`timescale 1ns/1ps
module scd_divider_tb;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  scd_pkg::scd_req_s req = '0;
  logic              freq_change = 1'b0;
  logic              align_go = 1'b0;
  logic [3:0]        half_cyc = 4'h2;
  logic [7:0]        rdata;
  logic              clk_in;
  logic              align_in;
  logic              core_clk;
  logic              corr_locked;
  logic              align_seen;
  logic [7:0]        v;
  int                fail_count = 0;
  int                samples_checked = 0;
  int                p;
  int                h;
  scd_divider dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .clk_in(clk_in),
    .align_in(align_in), .freq_change(freq_change), .core_clk(core_clk),
    .corr_locked(corr_locked), .align_seen(align_seen));
  scd_clk_src src (.mclk(mclk), .half_cyc(half_cyc), .align_go(align_go), .clk_in(clk_in),
    .align_in(align_in));
  initial forever #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Expected core clock period in system cycles: ratio times the input period
  function automatic logic [15:0] exp_period(input logic [2:0] m1, input logic [3:0] hc);
    return (16'(m1) + 16'h1) * 16'h2 * 16'(hc);
  endfunction : exp_period
  // One register cycle; strobe drops a cycle later so it is never re-raised in one step
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(negedge mclk) req <= '{w, !w, a, d};
    @(negedge mclk) req <= '0;
  endtask : bus
  // Period and high time of the core clock in system cycles
  task automatic measure;
    logic o;
    @(posedge core_clk);
    p = 0;
    h = 0;
    o = 1'b1;
    repeat (80)
    begin
      @(negedge mclk);
      if (!o && core_clk) break;
      p++;
      h += int'(core_clk);
      o = core_clk;
    end
  endtask : measure
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(78750));
    repeat (16) @(negedge mclk);
    rst <= 1'b0;
    bus(0, 9'h100, 8'h00);
    check("ctrl reset", rdata, 8'h04);
    bus(0, 9'h0ff, 8'h00);
    check("unmapped read", rdata, 8'h00);
    // Every ratio with corrector on; off only where the ratio allows it
    for (int i = 0; i < 16; i++)
    begin
      if (i[3] && !(i[2:0] inside {3'd0, 3'd1, 3'd3, 3'd7})) continue;
      v = 8'($urandom);
      v[6:4] = i[2:0];
      v[2] = !i[3];
      half_cyc <= 4'($urandom_range(2, 1));
      @(negedge mclk) freq_change <= 1'b1;
      @(negedge mclk) freq_change <= 1'b0;
      check("unlock", corr_locked, 1'b0);
      bus(1, 9'h100, v);
      bus(0, 9'h100, 8'h00);
      check("ctrl readback", rdata, v & 8'h77);
      // Relock may restart once when the ratio change stretches one period
      repeat (300) @(negedge mclk);
      check("lock", corr_locked, !i[3]);
      measure();
      check("period", 16'(p), exp_period(i[2:0], half_cyc));
      if (!i[3] && i[0]) check("high time", 16'(h), 16'((i[2:0] + 1) * half_cyc));
    end
    // Alignment off, every pulse, one-shot
    for (int j = 0; j < 3; j++)
    begin
      bus(1, 9'h100, {5'h01, j[1], |j[1:0]});
      @(negedge mclk) align_go <= 1'b1;
      @(negedge mclk) align_go <= 1'b0;
      repeat (12) @(negedge mclk);
      check("align seen", align_seen, |j[1:0]);
    end
    // Input below the rate floor: corrector stays unlocked, raw duty passes through
    half_cyc <= 4'h4;
    bus(1, 9'h100, 8'h14);
    repeat (300) @(negedge mclk);
    check("slow lock", corr_locked, 1'b0);
    measure();
    check("slow period", 16'(p), exp_period(3'h1, 4'h4));
    check("slow high time", 16'(h), 16'h0008);
    report_and_stop();
  end
  // Watchdog well beyond the expected run of about 45 us
  initial
  begin
    #300us;
    fail_count++;
    report_and_stop();
  end
endmodule : scd_divider_tb
